// file: src/podc_top.sv
// Purpose: two divider channels feeding two output pairs, with a wishbone register file
// Assumes: ref_clk at 10 MHz stands for the divider input clock; all inputs synchronous
// Notes: source select and chip-level sync come in as plain ports
//
// Our own choice: the Wishbone register port.
`include "podc_regs.svh"
`default_nettype none
module podc_top
    import podc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sync_hold,
    input wire logic vco_lvl,
    input wire logic ext_lvl,
    input wire logic [1:0] dist_src_sel,
    output logic pair_b_output_a,
    output logic pair_b_output_b,
    output logic pair_c_output_a,
    output logic pair_c_output_b,
    output logic [1:0] dcc_active
);
    podc_top_state_t st_ff; // all state of the block
    podc_top_state_t nxt_st; // its next value

    logic ch1_div; // channel one divider output
    logic ch2_div; // channel two divider output
    logic div_in; // level fed to both dividers
    logic req; // fresh bus request this cycle
    logic [9:0] idx; // register index from the byte address
    logic aligned; // word aligned address
    logic wr_en; // write to byte lane zero

    // bus decode
    // only aligned words reach a register; a stray low address bit would
    // otherwise alias four byte addresses onto one register and hide
    // software address mistakes, so misaligned accesses read zero instead
    assign idx = wb_adr_i[11:2];
    assign aligned = wb_adr_i[1:0] == 2'h0;
    // ack high blocks a second take of the same request
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr_en = req && wb_we_i && wb_sel_i[0] && aligned;

    // divider input follows the distribution source select
    // limitation: code 01 and the unused code 11 both feed the external level,
    // since nothing else exists in this block to distribute
    assign div_in = (dist_src_sel == `PODC_SRC_VCO) ? vco_lvl : ext_lvl;

    // routing of one pair: direct path only for the two meaningful codes
    function automatic logic route_out(
        input logic direct,
        input logic [1:0] sel,
        input logic div
    );
        logic r;
        r = div;
        if (direct) begin
            if (sel == `PODC_SRC_VCO) begin
                r = vco_lvl;
            end else if (sel == `PODC_SRC_EXT) begin
                r = ext_lvl;
            end else begin
                r = div;
            end
        end
        return r;
    endfunction : route_out

    // duty correction applies while the divider itself drives the pair, except with the direct bit set and code 11
    function automatic logic dcc_on(
        input logic [7:0] ctrl,
        input logic [7:0] route
    );
        logic on;
        on = !route[`PODC_DCC_OFF] && !ctrl[`PODC_BYPASS];
        if (route[`PODC_DIRECT] && dist_src_sel != `PODC_SRC_NONE) begin
            // direct path skips the divider and its correction
            on = 1'b0;
        end
        return on;
    endfunction : dcc_on

    // next state: register writes, read capture, output flops
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        // register writes land at the taking edge
        if (wr_en) begin
            case (idx)
                `PODC_IDX_CH1_COUNTS: begin
                    nxt_st.ch1_counts = wb_dat_i[7:0];
                end
                `PODC_IDX_CH1_CTRL: begin
                    nxt_st.ch1_ctrl = wb_dat_i[7:0];
                end
                `PODC_IDX_CH1_ROUTE: begin
                    nxt_st.ch1_route = wb_dat_i[7:0] & `PODC_ROUTE_MASK;
                end
                `PODC_IDX_CH2_COUNTS: begin
                    nxt_st.ch2_counts = wb_dat_i[7:0];
                end
                `PODC_IDX_CH2_CTRL: begin
                    nxt_st.ch2_ctrl = wb_dat_i[7:0];
                end
                `PODC_IDX_CH2_ROUTE: begin
                    nxt_st.ch2_route = wb_dat_i[7:0] & `PODC_ROUTE_MASK;
                end
                default: begin
                    // status and unmapped: write ignored, still acked
                end
            endcase
        end
        // read data is captured when the request is taken
        if (req) begin
            nxt_st.rdata = 8'h00;
            if (aligned) begin
                case (idx)
                    `PODC_IDX_CH1_COUNTS: begin
                        nxt_st.rdata = st_ff.ch1_counts;
                    end
                    `PODC_IDX_CH1_CTRL: begin
                        nxt_st.rdata = st_ff.ch1_ctrl;
                    end
                    `PODC_IDX_CH1_ROUTE: begin
                        nxt_st.rdata = st_ff.ch1_route;
                    end
                    `PODC_IDX_CH2_COUNTS: begin
                        nxt_st.rdata = st_ff.ch2_counts;
                    end
                    `PODC_IDX_CH2_CTRL: begin
                        nxt_st.rdata = st_ff.ch2_ctrl;
                    end
                    `PODC_IDX_CH2_ROUTE: begin
                        nxt_st.rdata = st_ff.ch2_route;
                    end
                    `PODC_IDX_STATUS: begin
                        // live view of divider levels, duty correction and outputs
                        nxt_st.rdata = {ch2_div, ch1_div, st_ff.dcc, st_ff.outs};
                    end
                    default: begin
                        // unmapped reads as zero
                        nxt_st.rdata = 8'h00;
                    end
                endcase
            end
        end
        // both members of a pair carry the same clock
        nxt_st.outs[0] = route_out(st_ff.ch1_route[`PODC_DIRECT], dist_src_sel, ch1_div);
        nxt_st.outs[1] = nxt_st.outs[0];
        nxt_st.outs[2] = route_out(st_ff.ch2_route[`PODC_DIRECT], dist_src_sel, ch2_div);
        nxt_st.outs[3] = nxt_st.outs[2];
        nxt_st.dcc[0] = dcc_on(st_ff.ch1_ctrl, st_ff.ch1_route);
        nxt_st.dcc[1] = dcc_on(st_ff.ch2_ctrl, st_ff.ch2_route);
    end

    // state register with documented reset values
    // every field is reset on its own so the two control registers can
    // carry different values: only channel two starts bypassed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff.ch1_counts <= `PODC_RST_COUNTS;
            st_ff.ch1_ctrl <= `PODC_RST_CH1_CTRL;
            st_ff.ch1_route <= `PODC_RST_ROUTE;
            st_ff.ch2_counts <= `PODC_RST_COUNTS;
            st_ff.ch2_ctrl <= `PODC_RST_CH2_CTRL;
            st_ff.ch2_route <= `PODC_RST_ROUTE;
            st_ff.ack <= 1'b0;
            st_ff.rdata <= 8'h00;
            st_ff.outs <= 4'h0;
            st_ff.dcc <= 2'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // channel one divider
    podc_divider u_ch1 (
        .ref_clk(ref_clk),
        .rst(rst),
        .low_cnt(st_ff.ch1_counts[`PODC_LOW_HI:`PODC_LOW_LO]),
        .high_cnt(st_ff.ch1_counts[`PODC_HIGH_HI:`PODC_HIGH_LO]),
        .bypass(st_ff.ch1_ctrl[`PODC_BYPASS]),
        .ignore(st_ff.ch1_ctrl[`PODC_IGNORE]),
        .force_lvl(st_ff.ch1_ctrl[`PODC_FORCE]),
        .start_lvl(st_ff.ch1_ctrl[`PODC_START]),
        .phase(st_ff.ch1_ctrl[`PODC_PHASE_HI:`PODC_PHASE_LO]),
        .sync_hold(sync_hold),
        .in_lvl(div_in),
        .div_out(ch1_div)
    );

    // channel two divider, bypassed after reset
    podc_divider u_ch2 (
        .ref_clk(ref_clk),
        .rst(rst),
        .low_cnt(st_ff.ch2_counts[`PODC_LOW_HI:`PODC_LOW_LO]),
        .high_cnt(st_ff.ch2_counts[`PODC_HIGH_HI:`PODC_HIGH_LO]),
        .bypass(st_ff.ch2_ctrl[`PODC_BYPASS]),
        .ignore(st_ff.ch2_ctrl[`PODC_IGNORE]),
        .force_lvl(st_ff.ch2_ctrl[`PODC_FORCE]),
        .start_lvl(st_ff.ch2_ctrl[`PODC_START]),
        .phase(st_ff.ch2_ctrl[`PODC_PHASE_HI:`PODC_PHASE_LO]),
        .sync_hold(sync_hold),
        .in_lvl(div_in),
        .div_out(ch2_div)
    );

    // port drive, all from flops
    // trade-off: the extra output flop costs one cycle of latency on every
    // path but keeps the pads free of decode glitches
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.rdata};
    assign pair_b_output_a = st_ff.outs[0];
    assign pair_b_output_b = st_ff.outs[1];
    assign pair_c_output_a = st_ff.outs[2];
    assign pair_c_output_b = st_ff.outs[3];
    assign dcc_active = st_ff.dcc;

    // checks on routing, reset values and the bus answer
    default clocking tcb @(posedge ref_clk); endclocking
    default disable iff (rst);

    reset_bypass_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> st_ff.ch2_ctrl[`PODC_BYPASS] && !st_ff.ch1_ctrl[`PODC_BYPASS])
        else $error("bypass bits wrong after reset");
    route_div_a: assert property (!st_ff.ch1_route[`PODC_DIRECT] |=> pair_b_output_a == $past(ch1_div))
        else $error("pair b not driven by its divider");
    route_vco_a: assert property (st_ff.ch2_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_VCO
        |=> pair_c_output_a == $past(vco_lvl) && pair_c_output_b == $past(vco_lvl))
        else $error("pair c not fed from vco");
    route_ext_a: assert property (st_ff.ch1_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_EXT
        |=> pair_b_output_b == $past(ext_lvl))
        else $error("pair b not fed from external clock");
    route_none_a: assert property (st_ff.ch2_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_NONE
        |=> pair_c_output_b == $past(ch2_div))
        else $error("direct bit had effect with source 01");
    dcc_state_a: assert property (st_ff.ch1_route[`PODC_DCC_OFF] |=> !dcc_active[0])
        else $error("duty correction active while disabled");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    // both members of a pair are one flop copied, so they can never part
    pair_match_a: assert property (pair_b_output_a == pair_b_output_b && pair_c_output_a == pair_c_output_b)
        else $error("pair members differ");
    // second pair on its own divider when the direct bit is clear
    route_ch2_div_a: assert property (!st_ff.ch2_route[`PODC_DIRECT] |=> pair_c_output_a == $past(ch2_div))
        else $error("pair c not driven by its divider");
    // first pair straight from the vco
    route_vco_b_a: assert property (st_ff.ch1_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_VCO
        |=> pair_b_output_a == $past(vco_lvl))
        else $error("pair b not fed from vco");
    // second pair straight from the external clock
    route_ext_c_a: assert property (st_ff.ch2_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_EXT
        |=> pair_c_output_a == $past(ext_lvl))
        else $error("pair c not fed from external clock");
    // code 01 leaves the first pair on its divider
    route_none_b_a: assert property (st_ff.ch1_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_NONE
        |=> pair_b_output_a == $past(ch1_div))
        else $error("direct bit had effect on pair b with source 01");
    // correction in effect while the divider drives the pair and nothing disables it
    dcc_on_a: assert property (!st_ff.ch1_route[`PODC_DCC_OFF] && !st_ff.ch1_ctrl[`PODC_BYPASS]
        && !st_ff.ch1_route[`PODC_DIRECT] |=> dcc_active[0])
        else $error("duty correction off while enabled");
    // second channel disable bit honoured as well
    dcc_off_c_a: assert property (st_ff.ch2_route[`PODC_DCC_OFF] |=> !dcc_active[1])
        else $error("channel two duty correction active while disabled");
    // a taken write lands in the addressed register at the taking edge
    write_land_a: assert property (wr_en && idx == `PODC_IDX_CH1_CTRL |=> st_ff.ch1_ctrl == $past(wb_dat_i[7:0]))
        else $error("control write did not land");
    // upper read lanes are always zero, only byte lane zero is backed
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");

    vco_route_c: cover property (st_ff.ch2_route[`PODC_DIRECT] && dist_src_sel == `PODC_SRC_VCO);
    sync_pulse_c: cover property (sync_hold ##1 !sync_hold ##[1:40] $rose(pair_b_output_a));
    unbypass_c: cover property ($fell(st_ff.ch2_ctrl[`PODC_BYPASS]));
endmodule : podc_top
`default_nettype wire

// file: src/podc_regs.svh
// Purpose: register indices, field positions and reset values of the divider channels
// Assumes: a register's byte address is four times its index
// Notes: definitions only
`ifndef PODC_REGS_SVH
`define PODC_REGS_SVH
// register indices, byte address = index * 4
`define PODC_IDX_CH1_COUNTS 10'h193
`define PODC_IDX_CH1_CTRL 10'h194
`define PODC_IDX_CH1_ROUTE 10'h195
`define PODC_IDX_CH2_COUNTS 10'h196
`define PODC_IDX_CH2_CTRL 10'h197
`define PODC_IDX_CH2_ROUTE 10'h198
`define PODC_IDX_STATUS 10'h1F0
// reset values
`define PODC_RST_COUNTS 8'h00
`define PODC_RST_CH1_CTRL 8'h00
`define PODC_RST_CH2_CTRL 8'h80
`define PODC_RST_ROUTE 8'h00
`define PODC_ROUTE_MASK 8'h03
// counts register fields
`define PODC_LOW_HI 7
`define PODC_LOW_LO 4
`define PODC_HIGH_HI 3
`define PODC_HIGH_LO 0
// control register fields
`define PODC_BYPASS 7
`define PODC_IGNORE 6
`define PODC_FORCE 5
`define PODC_START 4
`define PODC_PHASE_HI 3
`define PODC_PHASE_LO 0
// routing register fields
`define PODC_DIRECT 1
`define PODC_DCC_OFF 0
// distribution source select codes
`define PODC_SRC_EXT 2'h0
`define PODC_SRC_NONE 2'h1
`define PODC_SRC_VCO 2'h2
`endif

// file: src/podc_pkg.sv
// Purpose: state types of the paired output clock divider
// Assumes: nothing beyond the register header
// Notes: one packed struct per module holds all its state
`default_nettype none
package podc_pkg;
    // one divider channel
    typedef struct packed {
        logic lvl;       // present output level
        logic [3:0] cnt; // cycles spent in the present level
        logic [3:0] ph;  // phase cycles still to wait
    } podc_div_state_t;

    // register file, bus answer and output flops
    typedef struct packed {
        logic [7:0] ch1_counts;
        logic [7:0] ch1_ctrl;
        logic [7:0] ch1_route;
        logic [7:0] ch2_counts;
        logic [7:0] ch2_ctrl;
        logic [7:0] ch2_route;
        logic ack;
        logic [7:0] rdata;
        logic [3:0] outs;
        logic [1:0] dcc;
    } podc_top_state_t;
endpackage : podc_pkg
`default_nettype wire

// file: src/podc_divider.sv
// Purpose: one divider channel with counts, start level, phase hold, force and bypass
// Assumes: ref_clk stands for the divider input clock; sync_hold is synchronous
// Notes: div_out comes straight from a flop
`include "podc_regs.svh"
`default_nettype none
module podc_divider
    import podc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] low_cnt,
    input wire logic [3:0] high_cnt,
    input wire logic bypass,
    input wire logic ignore,
    input wire logic force_lvl,
    input wire logic start_lvl,
    input wire logic [3:0] phase,
    input wire logic sync_hold,
    input wire logic in_lvl,
    output logic div_out
);
    podc_div_state_t st_ff; // all divider state
    podc_div_state_t nxt_st; // its next value

    // next state: bypass beats sync, sync beats phase wait, phase wait beats counting
    always_comb begin
        nxt_st = st_ff;
        if (bypass) begin
            // divider idle, input level passed on
            nxt_st.lvl = in_lvl;
            nxt_st.cnt = 4'h0;
            nxt_st.ph = 4'h0;
        end else if (sync_hold && ignore) begin
            // forced level only meaningful while sync is ignored
            nxt_st.lvl = force_lvl;
        end else if (sync_hold) begin
            // obeying divider restarts and waits out the phase
            nxt_st.lvl = start_lvl;
            nxt_st.cnt = 4'h0;
            nxt_st.ph = phase;
        end else if (st_ff.ph != 4'h0) begin
            nxt_st.ph = st_ff.ph - 4'h1;
        end else if (st_ff.cnt == (st_ff.lvl ? high_cnt : low_cnt)) begin
            // field value plus one cycles spent, flip
            nxt_st.lvl = ~st_ff.lvl;
            nxt_st.cnt = 4'h0;
        end else begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign div_out = st_ff.lvl;

    // helper: length of the present level and whether it ran undisturbed
    logic normal; // plain counting this cycle
    logic toggle; // level flips at the next edge
    logic [3:0] run_ff;
    logic clean_ff;
    assign normal = !bypass && !sync_hold && (st_ff.ph == 4'h0);
    assign toggle = nxt_st.lvl != st_ff.lvl;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_ff <= 4'h0;
            clean_ff <= 1'b0;
        end else begin
            run_ff <= toggle ? 4'h0 : run_ff + 4'h1;
            clean_ff <= toggle ? normal : (clean_ff && normal);
        end
    end

    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (rst);

    high_len_a: assert property (toggle && normal && clean_ff && st_ff.lvl |-> run_ff == high_cnt)
        else $error("high time differs from high count plus one");
    low_len_a: assert property (toggle && normal && clean_ff && !st_ff.lvl |-> run_ff == low_cnt)
        else $error("low time differs from low count plus one");
    bypass_pass_a: assert property (bypass |=> div_out == $past(in_lvl))
        else $error("bypassed divider did not pass its input");
    sync_start_a: assert property (sync_hold && !ignore && !bypass |=> div_out == $past(start_lvl))
        else $error("sync restart did not apply start level");
    forced_lvl_a: assert property (sync_hold && ignore && !bypass |=> div_out == $past(force_lvl))
        else $error("ignoring divider not at forced level");
    phase_hold_a: assert property (!bypass && !sync_hold && st_ff.ph != 4'h0 |=> $stable(div_out))
        else $error("output moved during phase wait");
    run_full_c: cover property (toggle && normal && clean_ff);
endmodule : podc_divider
`default_nettype wire

// file: bench/test_podc_top.sv
// Purpose: self-checking bench for the paired output clock divider
// Assumes: one-cycle registered ack, status word at byte address 7C0
// Notes: driver queues expected results, a monitor pops and compares them
`default_nettype none
module test_podc_top;
    timeunit 1ns;
    timeprecision 1ns;
    // one compare, counted either way
    `define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin err_count++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
    typedef struct {string nm; logic [31:0] val; logic [31:0] msk;} podc_note_t;
    podc_note_t note_q[$]; // expected results, oldest first
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sync_hold = 1'b0;
    logic vco_lvl = 1'b0;
    logic ext_lvl = 1'b0;
    logic [1:0] dist_src_sel = 2'h0;
    logic pair_b_output_a;
    logic pair_b_output_b;
    logic pair_c_output_a;
    logic pair_c_output_b;
    logic [1:0] dcc_active;
    int err_count = 0;
    int tests_run = 0;
    integer seed = 32'h330B; // fixed seed keeps runs repeatable
    logic trk = 1'b0; // run-length tracking of channel one
    logic sync_prev = 1'b0;
    logic armed = 1'b0;
    logic lvl;
    int run;

    podc_top i_podc_top (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_hold(sync_hold), .vco_lvl(vco_lvl),
        .ext_lvl(ext_lvl), .dist_src_sel(dist_src_sel), .pair_b_output_a(pair_b_output_a),
        .pair_b_output_b(pair_b_output_b), .pair_c_output_a(pair_c_output_a),
        .pair_c_output_b(pair_c_output_b), .dcc_active(dcc_active));

    // 100 ns period
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // verdict and end of run, the only exit
    task automatic finish_test();
        $display("errors %0d in %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic note(input string nm, input logic [31:0] v, input logic [31:0] m);
        note_q.push_back('{nm, v, m});
    endtask : note

    // compare one observed result with the oldest note
    task automatic take(input logic [31:0] got);
        podc_note_t nt;
        if (note_q.size() == 0) begin
            err_count++;
            $display("[FAIL] unexpected result expected none seen %0h", got);
        end else begin
            nt = note_q.pop_front();
            `CHK(nt.nm, nt.val & nt.msk, got & nt.msk)
        end
    endtask : take

    // classic single cycle, held until ack is sampled, bounded wait
    task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d, input logic [3:0] sel);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            $display("[FAIL] bus ack expected 1 seen %b", wb_ack_o);
            finish_test();
        end
    endtask : wb

    task automatic wr(input logic [11:0] adr, input logic [7:0] d);
        wb(1'b1, adr, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [11:0] adr, input logic [7:0] e, input logic [7:0] m);
        note($sformatf("read %0h", adr), {24'h000000, e}, {24'hFFFFFF, m});
        wb(1'b0, adr, 8'h00, 4'hF);
    endtask : rd

    // monitor: read data on ack, level runs of channel one after sync release
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            take(wb_dat_o);
        end
        if (!trk) begin
            armed = 1'b0;
        end else if (!armed) begin
            if (sync_prev === 1'b1 && sync_hold === 1'b0) begin
                armed = 1'b1;
                run = 0;
                lvl = pair_b_output_a;
                take({31'h00000000, lvl});
            end
        end else if (pair_b_output_a !== lvl) begin
            // runs after the last note are left alone: the driver may see the empty queue one edge late
            if (note_q.size() != 0) begin
                take(run);
            end
            lvl = pair_b_output_a;
            run = 1;
        end else begin
            run++;
        end
        sync_prev = sync_hold;
    end

    // ctrl, route, {sel, vco, ext}, expected status; channel two bypassed and routed to its divider
    logic [31:0] tbl [11] = '{32'h60020ACF, 32'h60020940, 32'h600201CF, 32'h60020240, 32'h60020453,
        32'h60000853, 32'h60010443, 32'h40000410, 32'h80000ACF, 32'h80000200, 32'h800001CF};
    // counts, control (start level and phase)
    logic [15:0] dv [3] = '{16'h3514, 16'h0000, 16'hF20F};
    logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};

    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] d0;
        logic [11:0] a;
        int hi;
        int lo;
        int ph;
        int fa;
        int fb;
        int n;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, channel two bypassed, channel one not
        for (int i = 0; i < 6; i++) begin
            rd(12'h64C + 12'(4 * i), rst_v[i], 8'hFF);
        end
        // random write and read back, routing keeps only two bits
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            a = 12'h64C + 12'(4 * i);
            if (i == 0) begin
                d0 = d;
            end
            wr(a, d);
            rd(a, (i == 2 || i == 5) ? (d & 8'h03) : d, 8'hFF);
        end
        wb(1'b1, 12'h64C, ~d0, 4'hE); // lane zero not selected: stores nothing
        rd(12'h64C, d0, 8'hFF);
        wr(12'h680, 8'h5A); // unmapped write is ignored
        rd(12'h680, 8'h00, 8'hFF);
        rd(12'h651, 8'h00, 8'hFF); // misaligned reads zero
        wr(12'h65C, 8'h80);
        wr(12'h660, 8'h00); // channel two pair back on its divider
        // forced level, bypass and direct routing with sync held
        @(posedge ref_clk);
        sync_hold <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            wr(12'h650, tbl[i][31:24]);
            wr(12'h654, tbl[i][23:16]);
            @(posedge ref_clk);
            dist_src_sel <= tbl[i][11:10];
            vco_lvl <= tbl[i][9];
            ext_lvl <= tbl[i][8];
            repeat (4) @(posedge ref_clk);
            rd(12'h7C0, tbl[i][7:0], 8'hFF);
        end
        // divider runs after a sync pulse
        wr(12'h654, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            sync_hold <= 1'b1;
            wr(12'h64C, dv[i][15:8]);
            wr(12'h650, dv[i][7:0]);
            hi = dv[i][11:8];
            lo = dv[i][15:12];
            ph = dv[i][3:0];
            fa = dv[i][4] ? hi : lo;
            fb = dv[i][4] ? lo : hi;
            note("start level", {31'h00000000, dv[i][4]}, 32'hFFFFFFFF);
            note("first run", ph + fa + 1, 32'hFFFFFFFF);
            note("run", fb + 1, 32'hFFFFFFFF);
            note("run", fa + 1, 32'hFFFFFFFF);
            note("run", fb + 1, 32'hFFFFFFFF);
            trk <= 1'b1;
            @(posedge ref_clk);
            sync_hold <= 1'b0;
            n = 0;
            while (note_q.size() != 0 && n < 300) begin
                @(posedge ref_clk);
                n++;
            end
            if (note_q.size() != 0) begin
                err_count++;
                $display("[FAIL] divider runs expected %0d more seen none", note_q.size());
                finish_test();
            end
            trk <= 1'b0;
        end
        finish_test();
    end
endmodule : test_podc_top
`default_nettype wire
